// ===== logic/current_sink_port_irq.sv
// Local design decision: register access over APB.
`timescale 1ns/1ps
module current_sink_port_irq
   import sink_port_pkg::*;
(
   input  wire logic               CLK_SYS,
   input  wire logic               RST_N,
   input  wire logic               PSEL,
   input  wire logic               PENABLE,
   input  wire logic               PWRITE,
   input  wire logic [11:0]        PADDR,
   input  wire logic [31:0]        PWDATA,
   output logic      [31:0]        PRDATA,
   output logic                    PREADY,
   output logic                    PSLVERR,
   input  wire logic [7:0]         PIN_IN,
   output logic      [7:0]         PIN_OUT,
   output logic      [7:0]         PIN_OE,
   output logic      [7:0]         PIN_PULLUP,
   output logic      [8*7-1:0]     SINK_LEVEL,
   output logic                    IRQ
);
   // ****************************************
   // Register file
   // ****************************************
   logic [7:0]         irq_en_q;
   logic [7:0]         edge_sel_q;
   logic [7:0]         data_q;
   logic [7:0]         ctrl_q;
   logic [7:0]         status_q;
   logic [7:0]         mask_q;
   logic [3:0]         strength_q [NUM_PINS];
   logic [7:0]         hit;
   logic               wr;
   logic               rd;
   logic               ok;
   logic [7:0]         idx;
   logic [7:0]         rdata;

   function automatic logic valid_idx(input logic [7:0] i);
      valid_idx = (i >= IDX_DATA && i <= IDX_PIN_IN) || (i >= IDX_STRENGTH0 && i <= IDX_STRENGTH0 + 8'h07);
   endfunction

   assign idx     = PADDR[9:2];
   assign ok      = valid_idx(idx) && PADDR[1:0] == 2'b00 && PADDR[11:10] == 2'b00;
   assign wr      = PSEL & PENABLE & PWRITE & ok;
   assign rd      = PSEL & PENABLE & ~PWRITE;
   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL & PENABLE & ~ok;

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         irq_en_q   <= RST_IRQ_EN;
         edge_sel_q <= RST_EDGE_SEL;
         data_q     <= RST_DATA;
         ctrl_q     <= RST_CTRL;
         mask_q     <= RST_MASK;
      end else if (wr) begin
         if (idx == IDX_IRQ_EN) begin
            irq_en_q <= PWDATA[7:0];
         end else if (idx == IDX_EDGE_SEL) begin
            edge_sel_q <= PWDATA[7:0];
         end else if (idx == IDX_DATA) begin
            data_q <= PWDATA[7:0];
         end else if (idx == IDX_CTRL) begin
            ctrl_q <= PWDATA[7:0];
         end else if (idx == IDX_MASK) begin
            mask_q <= PWDATA[7:0];
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g++) begin : g_pin
         always_ff @(posedge CLK_SYS) begin
            if (!RST_N) begin
               strength_q[g] <= RST_STRENGTH;
            end else if (wr && idx == IDX_STRENGTH0 + 8'(g)) begin
               strength_q[g] <= PWDATA[3:0];
            end
         end
         edge_catch u_edge (
            .CLK_SYS    (CLK_SYS),
            .RST_N      (RST_N),
            .pin_in     (PIN_IN[g]),
            .rising_sel (edge_sel_q[g]),
            .enable     (irq_en_q[g]),
            .hit        (hit[g])
         );
         sink_level u_level (
            .code    (strength_q[g]),
            .sink_on (~data_q[g] & ~ctrl_q[CTRL_SUSPEND]),
            .level   (SINK_LEVEL[g*7 +: 7])
         );
      end
   endgenerate

   // ****************************************
   // Pin drive
   // ****************************************
   assign PIN_OUT    = 8'h00;
   assign PIN_OE     = ~data_q & ~{8{ctrl_q[CTRL_SUSPEND]}};
   assign PIN_PULLUP = data_q;

   // ****************************************
   // Pending status, set wins over clear
   // ****************************************
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         status_q <= RST_STATUS;
      end else begin
         status_q <= (status_q & ~(wr && idx == IDX_STATUS ? PWDATA[7:0] : 8'h00)) | hit;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(status_q & mask_q);
      end
   end

   always_comb begin
      rdata = 8'h00;
      if (idx == IDX_DATA) begin
         rdata = data_q;
      end else if (idx == IDX_CTRL) begin
         rdata = ctrl_q;
      end else if (idx == IDX_STATUS) begin
         rdata = status_q;
      end else if (idx == IDX_MASK) begin
         rdata = mask_q;
      end else if (idx == IDX_PIN_IN) begin
         rdata = PIN_IN;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         PRDATA <= 32'h0000_0000;
      end else if (PSEL & ~PENABLE & ~PWRITE) begin
         PRDATA <= {24'h000000, rdata};
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   property p_reset_en;
      @(posedge CLK_SYS) $rose(RST_N) |-> irq_en_q == 8'h00 && edge_sel_q == 8'h00;
   endproperty
   a_reset_en: assert property (p_reset_en) else $error("enables not cleared");

   property p_fall;
      @(posedge CLK_SYS) disable iff (!RST_N)
         (irq_en_q[0] && !edge_sel_q[0] && !hit[0] ##1 hit[0]) |-> ##1 status_q[0];
   endproperty
   a_fall: assert property (p_fall) else $error("edge not latched");

   property p_blocked;
      @(posedge CLK_SYS) disable iff (!RST_N) !irq_en_q[0] |-> !hit[0];
   endproperty
   a_blocked: assert property (p_blocked) else $error("disabled pin hit");

   property p_irq;
      @(posedge CLK_SYS) disable iff (!RST_N) |(status_q & mask_q) |=> IRQ;
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing");

   property p_suspend;
      @(posedge CLK_SYS) disable iff (!RST_N) ctrl_q[CTRL_SUSPEND] |-> PIN_OE == 8'h00 && SINK_LEVEL == '0;
   endproperty
   a_suspend: assert property (p_suspend) else $error("sink active in suspend");

   property p_high;
      @(posedge CLK_SYS) disable iff (!RST_N) data_q[1] |-> !PIN_OE[1] && PIN_PULLUP[1];
   endproperty
   a_high: assert property (p_high) else $error("pin not pulled high");

   property p_levels;
      @(posedge CLK_SYS) disable iff (!RST_N)
         (PIN_OE[2] && strength_q[2] == 4'hF) |-> SINK_LEVEL[20:14] == 7'd75;
   endproperty
   a_levels: assert property (p_levels) else $error("max level wrong");

   property p_min;
      @(posedge CLK_SYS) disable iff (!RST_N)
         (PIN_OE[3] && strength_q[3] == 4'h0) |-> SINK_LEVEL[27:21] * 5 == 75;
   endproperty
   a_min: assert property (p_min) else $error("min level wrong");

   property p_strwr;
      @(posedge CLK_SYS) disable iff (!RST_N)
         (wr && idx == IDX_STRENGTH0 + 8'h07) |=> strength_q[7] == $past(PWDATA[3:0]);
   endproperty
   a_strwr: assert property (p_strwr) else $error("strength write lost");

   // ****************************************
   // Bus checks
   // ****************************************
   property p_slverr_align;
      @(posedge CLK_SYS) disable iff (!RST_N)
         PSEL && PENABLE && PADDR[1:0] != 2'b00 |-> PSLVERR;
   endproperty
   a_slverr_align: assert property (p_slverr_align) else $error("unaligned access accepted");

   property p_slverr_gap;
      @(posedge CLK_SYS) disable iff (!RST_N)
         PSEL && PENABLE && idx == IDX_PIN_IN + 8'h01 |-> PSLVERR;
   endproperty
   a_slverr_gap: assert property (p_slverr_gap) else $error("gap address accepted");

   property p_slverr_ok;
      @(posedge CLK_SYS) disable iff (!RST_N)
         PSEL && PENABLE && PADDR == {2'b00, IDX_STRENGTH0, 2'b00} |-> !PSLVERR;
   endproperty
   a_slverr_ok: assert property (p_slverr_ok) else $error("mapped address refused");

   property p_rd_stands;
      @(posedge CLK_SYS) disable iff (!RST_N)
         rd |=> $stable(PRDATA);
   endproperty
   a_rd_stands: assert property (p_rd_stands) else $error("read data moved after access");

   property p_rd_status;
      @(posedge CLK_SYS) disable iff (!RST_N)
         PSEL && !PENABLE && !PWRITE && idx == IDX_STATUS |=> PRDATA == {24'h000000, $past(status_q)};
   endproperty
   a_rd_status: assert property (p_rd_status) else $error("status read wrong");

   property p_rd_wo;
      @(posedge CLK_SYS) disable iff (!RST_N)
         PSEL && !PENABLE && !PWRITE && (idx == IDX_IRQ_EN || idx == IDX_EDGE_SEL) |=> PRDATA == 32'h0000_0000;
   endproperty
   a_rd_wo: assert property (p_rd_wo) else $error("write-only register read nonzero");

   property p_rd_strength;
      @(posedge CLK_SYS) disable iff (!RST_N)
         PSEL && !PENABLE && !PWRITE && idx == IDX_STRENGTH0 + 8'h07 |=> PRDATA == 32'h0000_0000;
   endproperty
   a_rd_strength: assert property (p_rd_strength) else $error("strength read nonzero");

   property p_wr_en;
      @(posedge CLK_SYS) disable iff (!RST_N)
         wr && idx == IDX_IRQ_EN |=> irq_en_q == $past(PWDATA[7:0]);
   endproperty
   a_wr_en: assert property (p_wr_en) else $error("enable write lost");

   property p_wr_pol;
      @(posedge CLK_SYS) disable iff (!RST_N)
         wr && idx == IDX_EDGE_SEL |=> edge_sel_q == $past(PWDATA[7:0]);
   endproperty
   a_wr_pol: assert property (p_wr_pol) else $error("polarity write lost");

   property p_wr_data;
      @(posedge CLK_SYS) disable iff (!RST_N)
         wr && idx == IDX_DATA |=> data_q == $past(PWDATA[7:0]);
   endproperty
   a_wr_data: assert property (p_wr_data) else $error("data write lost");

   property p_wr_strength0;
      @(posedge CLK_SYS) disable iff (!RST_N)
         wr && idx == IDX_STRENGTH0 |=> strength_q[0] == $past(PWDATA[3:0]);
   endproperty
   a_wr_strength0: assert property (p_wr_strength0) else $error("pin 0 strength write lost");

   property p_bad_wr;
      @(posedge CLK_SYS) disable iff (!RST_N)
         PSEL && PENABLE && PWRITE && !ok |=> $stable(irq_en_q) && $stable(edge_sel_q) && $stable(data_q);
   endproperty
   a_bad_wr: assert property (p_bad_wr) else $error("refused write changed a register");

   // ****************************************
   // Pin checks
   // ****************************************
   property p_sink_pin0;
      @(posedge CLK_SYS) disable iff (!RST_N)
         !ctrl_q[CTRL_SUSPEND] && !data_q[0] |-> PIN_OE[0] && !PIN_PULLUP[0];
   endproperty
   a_sink_pin0: assert property (p_sink_pin0) else $error("pin not sinking");

   property p_off_level;
      @(posedge CLK_SYS) disable iff (!RST_N)
         !PIN_OE[5] |-> SINK_LEVEL[41:35] == 7'h00;
   endproperty
   a_off_level: assert property (p_off_level) else $error("level while sink off");

   property p_mid;
      @(posedge CLK_SYS) disable iff (!RST_N)
         PIN_OE[4] && strength_q[4] == 4'h8 |-> SINK_LEVEL[34:28] == 7'h2F;
   endproperty
   a_mid: assert property (p_mid) else $error("middle level wrong");

   property p_step;
      @(posedge CLK_SYS) disable iff (!RST_N)
         PIN_OE[0] && PIN_OE[1] && strength_q[0] < 4'hE && strength_q[1] == strength_q[0] + 4'h2
         |-> SINK_LEVEL[13:7] == SINK_LEVEL[6:0] + 7'h08;
   endproperty
   a_step: assert property (p_step) else $error("level steps uneven");

   property p_strength_hold;
      @(posedge CLK_SYS) disable iff (!RST_N)
         !(wr && idx == IDX_STRENGTH0 + 8'h07) |=> $stable(strength_q[7]);
   endproperty
   a_strength_hold: assert property (p_strength_hold) else $error("strength changed unwritten");

   // ****************************************
   // Interrupt checks
   // ****************************************
   property p_rise;
      @(posedge CLK_SYS) disable iff (!RST_N)
         (irq_en_q[1] && edge_sel_q[1] && !hit[1] ##1 hit[1]) |-> ##1 status_q[1];
   endproperty
   a_rise: assert property (p_rise) else $error("rising edge not latched");

   property p_set;
      @(posedge CLK_SYS) disable iff (!RST_N)
         |hit |=> (status_q & $past(hit)) == $past(hit);
   endproperty
   a_set: assert property (p_set) else $error("hit not pending");

   property p_clear;
      @(posedge CLK_SYS) disable iff (!RST_N)
         wr && idx == IDX_STATUS && hit == 8'h00 |=> (status_q & $past(PWDATA[7:0])) == 8'h00;
   endproperty
   a_clear: assert property (p_clear) else $error("pending not cleared");

   property p_hold;
      @(posedge CLK_SYS) disable iff (!RST_N)
         !(wr && idx == IDX_STATUS) |=> (status_q & $past(status_q)) == $past(status_q);
   endproperty
   a_hold: assert property (p_hold) else $error("pending lost");

   property p_irq_low;
      @(posedge CLK_SYS) disable iff (!RST_N)
         (status_q & mask_q) == 8'h00 |=> !IRQ;
   endproperty
   a_irq_low: assert property (p_irq_low) else $error("irq without pending");

   property p_enable_gate;
      @(posedge CLK_SYS) disable iff (!RST_N)
         (hit & ~irq_en_q) == 8'h00;
   endproperty
   a_enable_gate: assert property (p_enable_gate) else $error("hit on disabled pin");

   property p_status_src;
      @(posedge CLK_SYS) disable iff (!RST_N)
         $rose(status_q[2]) |-> $past(hit[2]);
   endproperty
   a_status_src: assert property (p_status_src) else $error("pending without hit");
endmodule // current_sink_port_irq

// ===== logic/edge_catch.sv
`timescale 1ns/1ps
module edge_catch
   import sink_port_pkg::*;
(
   input  wire logic CLK_SYS,
   input  wire logic RST_N,
   input  wire logic pin_in,
   input  wire logic rising_sel,
   input  wire logic enable,
   output logic      hit
);
   logic s1_q, s2_q, prev_q;
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         s1_q   <= 1'b1;
         s2_q   <= 1'b1;
         prev_q <= 1'b1;
      end else begin
         s1_q   <= pin_in;
         s2_q   <= s1_q;
         prev_q <= s2_q;
      end
   end
   assign hit = enable & (rising_sel ? (s2_q & ~prev_q) : (~s2_q & prev_q));
endmodule // edge_catch

// ===== logic/sink_level.sv
`timescale 1ns/1ps
module sink_level
   import sink_port_pkg::*;
(
   input  wire logic [CODE_W-1:0]  code,
   input  wire logic               sink_on,
   output logic      [LEVEL_W-1:0] level
);
   logic [LEVEL_W-1:0] full;
   // Min plus code times step: 15..75, linear
   assign full  = LEVEL_MIN + LEVEL_STEP * {3'h0, code};
   assign level = sink_on ? full : 7'h00;
endmodule // sink_level

// ===== logic/sink_port_pkg.sv
package sink_port_pkg;
   localparam int          NUM_PINS       = 8;
   localparam int          CODE_W         = 4;
   localparam int          LEVEL_W        = 7;
   // Index form: byte address = 4 * index
   localparam logic [7:0]  IDX_IRQ_EN     = 8'h31;
   localparam logic [7:0]  IDX_EDGE_SEL   = 8'h32;
   localparam logic [7:0]  IDX_STRENGTH0  = 8'h38;
   localparam logic [7:0]  IDX_DATA       = 8'h30;
   localparam logic [7:0]  IDX_CTRL       = 8'h33;
   localparam logic [7:0]  IDX_STATUS     = 8'h34;
   localparam logic [7:0]  IDX_MASK       = 8'h35;
   localparam logic [7:0]  IDX_PIN_IN     = 8'h36;
   localparam int          CTRL_SUSPEND   = 3;
   localparam logic [7:0]  RST_IRQ_EN     = 8'h00;
   localparam logic [7:0]  RST_EDGE_SEL   = 8'h00;
   localparam logic [7:0]  RST_DATA       = 8'hFF;
   localparam logic [3:0]  RST_STRENGTH   = 4'h0;
   localparam logic [7:0]  RST_MASK       = 8'h00;
   localparam logic [7:0]  RST_CTRL       = 8'h00;
   localparam logic [7:0]  RST_STATUS     = 8'h00;
   // Level scale: max 75, min 15 (one fifth), step 4 per code
   localparam logic [6:0]  LEVEL_MIN      = 7'h0F;
   localparam logic [6:0]  LEVEL_STEP     = 7'h04;
endpackage

// ===== tb/current_sink_port_irq_tb.sv
`timescale 1ns/1ps
module current_sink_port_irq_tb;
   import sink_port_pkg::*;
   logic        CLK_SYS = 1'h0, RST_N = 1'h0, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0, PRDATA, rd;
   logic        PREADY, PSLVERR, IRQ, err;
   logic [7:0]  PIN_IN, PIN_OUT, PIN_OE, PIN_PULLUP, ext_en = 8'h00, ext_val = 8'h00;
   logic [55:0] SINK_LEVEL;
   int          miscompares = 0, n_compared = 0;

   always #25 CLK_SYS = ~CLK_SYS;

   current_sink_port_irq current_sink_port_irq_i (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
      .PIN_PULLUP(PIN_PULLUP), .SINK_LEVEL(SINK_LEVEL), .IRQ(IRQ));
   pin_load pin_load_i (.clk(CLK_SYS), .oe(PIN_OE), .pull_on(PIN_PULLUP), .ext_en(ext_en),
      .ext_val(ext_val), .lvl(PIN_IN));

   // ****
   // Shared tasks
   // ****
   task automatic tally_and_finish;
      if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
      @(posedge CLK_SYS);
      PSEL <= 1'h1;
      PWRITE <= w;
      PADDR <= {2'h0, idx, 2'h0};
      PWDATA <= wd;
      @(posedge CLK_SYS);
      PENABLE <= 1'h1;
      do @(posedge CLK_SYS); while (PREADY !== 1'h1);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'h0;
      PENABLE <= 1'h0;
   endtask

   task automatic pins(input logic [7:0] en, input logic exp, input string m);
      @(posedge CLK_SYS);
      ext_en <= en;
      repeat (8) @(posedge CLK_SYS);
      chk({31'h0, IRQ}, {31'h0, exp}, m);
   endtask

   // ****
   // Scenarios
   // ****
   task automatic t_sink;
      int code;
      chk({8'h0, PIN_OE, PIN_PULLUP, PIN_OUT}, 32'h0000FF00, "reset pins");
      apb(1'h0, IDX_DATA, 32'h0);
      chk(rd, 32'hFF, "data reset");
      apb(1'h1, IDX_DATA, 32'h0);
      for (int g = 0; g < 8; g++) begin
         code = (g == 7) ? 15 : 2 * g;
         apb(1'h1, IDX_STRENGTH0 + 8'(g), 32'(code));
      end
      @(posedge CLK_SYS);
      for (int g = 0; g < 8; g++) begin
         code = (g == 7) ? 15 : 2 * g;
         chk({25'h0, SINK_LEVEL[g*7+:7]}, 32'(15 + 4 * code), "level");
      end
      chk({8'h0, PIN_OE, PIN_PULLUP, PIN_OUT}, 32'h00FF0000, "sinking");
      apb(1'h1, IDX_CTRL, 32'h8);
      @(posedge CLK_SYS);
      chk({16'h0, PIN_OE, 7'h0, |SINK_LEVEL}, 32'h0, "suspend");
      apb(1'h1, IDX_CTRL, 32'h0);
      apb(1'h1, IDX_DATA, 32'hFF);
      apb(1'h0, 8'h37, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000, "unmapped");
      apb(1'h1, 8'h37, 32'h0);
      chk({31'h0, err}, 32'h1, "unmapped write");
   endtask

   task automatic t_irq;
      apb(1'h1, IDX_MASK, 32'hFF);
      pins(8'h01, 1'h0, "irq while disabled");
      apb(1'h1, IDX_IRQ_EN, 32'h03);
      pins(8'h00, 1'h0, "rise on default polarity");
      pins(8'h01, 1'h1, "fall irq");
      apb(1'h1, IDX_MASK, 32'h00);
      pins(8'h01, 1'h0, "masked pending");
      apb(1'h1, IDX_MASK, 32'hFF);
      apb(1'h0, IDX_STATUS, 32'h0);
      chk(rd, 32'h01, "status pin0");
      apb(1'h1, IDX_STATUS, 32'h01);
      pins(8'h00, 1'h0, "clear");
      apb(1'h1, IDX_EDGE_SEL, 32'h02);
      pins(8'h02, 1'h0, "fall on rising pin");
      pins(8'h00, 1'h1, "rise irq");
      apb(1'h0, IDX_STATUS, 32'h0);
      chk(rd, 32'h02, "status pin1");
      apb(1'h1, IDX_STATUS, 32'h02);
      pins(8'h04, 1'h0, "disabled pin");
      apb(1'h0, IDX_STATUS, 32'h0);
      chk(rd, 32'h00, "status disabled");
   endtask

   initial begin
      repeat (12) @(posedge CLK_SYS);
      RST_N <= 1'h1;
      t_sink();
      t_irq();
      tally_and_finish();
   end

   initial begin
      #100000;
      miscompares++;
      tally_and_finish();
   end
endmodule // current_sink_port_irq_tb

// ===== tb/pin_load.sv
`timescale 1ns/1ps
// ****
// External load on the sink pins
// ****
module pin_load (
   input  wire logic       clk,
   input  wire logic [7:0] oe,
   input  wire logic [7:0] pull_on,
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   output logic      [7:0] lvl
);
   logic [7:0] last_q;
   // Sink wins, then outside drive, then pull-up; a bare pin wanders
   assign lvl = ~oe & ((ext_en & ext_val) | (~ext_en & (pull_on | ~last_q)));
   always_ff @(posedge clk) begin
      last_q <= lvl;
   end
endmodule // pin_load
